// [logic/tpps_pkg.sv]
package tpps_pkg;

  // register geometry
  localparam int unsigned REG_W = 8;
  localparam int unsigned IDX_W = 8;
  localparam int unsigned NUM_SETTINGS = 8;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned SPREAD_W = 3;
  localparam int unsigned PROFILE_W = 30;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SPREAD_HI = 8'h30;
  localparam logic [IDX_W-1:0] IDX_SPREAD_MID = 8'h31;
  localparam logic [IDX_W-1:0] IDX_SPREAD_LO = 8'h32;
  localparam logic [IDX_W-1:0] IDX_VCO_SEL = 8'h33;
  localparam logic [IDX_W-1:0] IDX_ROUTING = 8'h34;
  localparam logic [IDX_W-1:0] IDX_STATE_SEL = 8'h35;
  localparam logic [IDX_W-1:0] IDX_DIRECTION = 8'h36;
  localparam logic [IDX_W-1:0] IDX_STATUS = 8'h20;

  // byte address lanes above the index must be zero
  localparam int unsigned ADDR_IDX_LO = 2;
  localparam int unsigned ADDR_IDX_HI = 9;
  localparam int unsigned ADDR_TOP_LO = 10;

  // reset values
  localparam logic [REG_W-1:0] RST_SPREAD = 8'h00;
  localparam logic [REG_W-1:0] RST_VCO_SEL = 8'h00;
  localparam logic [REG_W-1:0] RST_ROUTING = 8'hed;
  localparam logic [REG_W-1:0] RST_STATE_SEL = 8'h02;
  localparam logic [REG_W-1:0] RST_DIRECTION = 8'h00;

  // field positions in the routing and direction registers
  localparam int unsigned BYPASS_BIT = 7;
  localparam int unsigned SIXTH_SRC_BIT = 6;
  localparam int unsigned SEVENTH_SRC_HI = 5;
  localparam int unsigned SEVENTH_SRC_LO = 4;
  localparam int unsigned STATE_ONE_HI = 3;
  localparam int unsigned STATE_ONE_LO = 2;
  localparam int unsigned STATE_ZERO_HI = 1;
  localparam int unsigned STATE_ZERO_LO = 0;
  localparam int unsigned DIRECTION_BIT = 7;

  // output-state definition codes
  typedef enum logic [1:0] {
    OST_OFF_PD = 2'b00,
    OST_TRISTATE = 2'b01,
    OST_LOW = 2'b10,
    OST_ON = 2'b11
  } tpps_out_state_t;

  // seventh output source codes
  typedef enum logic [1:0] {
    SRC7_FOURTH = 2'b00,
    SRC7_SIXTH = 2'b01,
    SRC7_SEVENTH = 2'b10,
    SRC7_RSVD = 2'b11
  } tpps_src7_t;

  // bus constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;

  // spread amount in hundredths of a percent
  function automatic logic [7:0] tpps_spread_hundredths(input logic [SPREAD_W-1:0] code);
    logic [7:0] amt;
    case (code)
      3'h0: amt = 8'h00;
      3'h1: amt = 8'h19;
      3'h2: amt = 8'h32;
      3'h3: amt = 8'h4b;
      3'h4: amt = 8'h64;
      3'h5: amt = 8'h7d;
      3'h6: amt = 8'h96;
      default: amt = 8'hc8;
    endcase
    return amt;
  endfunction : tpps_spread_hundredths

endpackage : tpps_pkg

// [logic/tpps_setting_decode.sv]
`timescale 1ns/1ps
module tpps_setting_decode
  import tpps_pkg::*;
(
  input wire logic [REG_W-1:0] spreadHi,
  input wire logic [REG_W-1:0] spreadMid,
  input wire logic [REG_W-1:0] spreadLo,
  input wire logic [REG_W-1:0] vcoSel,
  input wire logic [REG_W-1:0] stateSel,
  input wire logic [SEL_W-1:0] settingIdx,
  output logic [SPREAD_W-1:0] spreadCode,
  output logic vcoProfileBit,
  output logic stateChoice
);

  logic [SPREAD_W*NUM_SETTINGS-1:0] packedFields;
  logic [SPREAD_W-1:0] spreadField [NUM_SETTINGS];

  // fields run msb-first across three bytes, setting 7 on top
  assign packedFields = {spreadHi, spreadMid, spreadLo};

  for (genvar n = 0; n < NUM_SETTINGS; n++)
  begin : g_field
    assign spreadField[n] = packedFields[SPREAD_W*n +: SPREAD_W];
  end

  // pick the active setting's fields
  assign spreadCode = spreadField[settingIdx];
  assign vcoProfileBit = vcoSel[settingIdx];
  // one state choice bit per setting
  assign stateChoice = stateSel[settingIdx];

endmodule : tpps_setting_decode

// [logic/tpps_top.sv]
`timescale 1ns/1ps
module tpps_top
  import tpps_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic settingSelectPinA,
  input wire logic settingSelectPinB,
  input wire logic settingSelectPinC,
  input wire logic [PROFILE_W-1:0] vcoProfileZero,
  input wire logic [PROFILE_W-1:0] vcoProfileOne,
  output logic [SPREAD_W-1:0] spreadAmountField,
  output logic [7:0] spreadHundredths,
  output logic spreadCenter,
  output logic vcoProfileBitOut,
  output logic [PROFILE_W-1:0] activeProfileWord,
  output logic pllBypass,
  output logic pllPowerDown,
  output logic sixthOutSource,
  output logic [1:0] seventhOutSource,
  output logic outTristate,
  output logic outDriveLow,
  output logic outEnable
);

  // register file
  logic [REG_W-1:0] spreadHi_q, spreadHi_d;
  logic [REG_W-1:0] spreadMid_q, spreadMid_d;
  logic [REG_W-1:0] spreadLo_q, spreadLo_d;
  logic [REG_W-1:0] vcoSel_q, vcoSel_d;
  logic [REG_W-1:0] routing_q, routing_d;
  logic [REG_W-1:0] stateSel_q, stateSel_d;
  logic [REG_W-1:0] direction_q, direction_d;
  // bus data phase
  logic wrPend_q, wrPend_d;
  logic [IDX_W-1:0] wrIdx_q, wrIdx_d;
  logic [31:0] rdData_q, rdData_d;
  // decoded outputs
  logic [SPREAD_W-1:0] spreadField_q, spreadField_d;
  logic [7:0] spreadAmt_q, spreadAmt_d;
  logic center_q, center_d;
  logic vcoBit_q, vcoBit_d;
  logic [PROFILE_W-1:0] profile_q, profile_d;
  logic bypass_q, bypass_d;
  logic powerDown_q, powerDown_d;
  logic sixthSrc_q, sixthSrc_d;
  logic [1:0] seventhSrc_q, seventhSrc_d;
  logic tristate_q, tristate_d;
  logic driveLow_q, driveLow_d;
  logic enable_q, enable_d;

  logic addrPhase;
  logic addrInRange;
  logic [IDX_W-1:0] addrIdx;
  logic [SEL_W-1:0] settingIdx;
  logic [SPREAD_W-1:0] selSpread;
  logic selVcoBit;
  logic selStateChoice;
  tpps_out_state_t activeState;

  // zero-wait slave, every answer okay
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = rdData_q;
  assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign addrIdx = haddr[ADDR_IDX_HI:ADDR_IDX_LO];
  assign addrInRange = (haddr[31:ADDR_TOP_LO] == 22'h000000);

  // select pins pick the active setting
  assign settingIdx = {settingSelectPinC, settingSelectPinB, settingSelectPinA};

  tpps_setting_decode u_decode (
    .spreadHi(spreadHi_q),
    .spreadMid(spreadMid_q),
    .spreadLo(spreadLo_q),
    .vcoSel(vcoSel_q),
    .stateSel(stateSel_q),
    .settingIdx(settingIdx),
    .spreadCode(selSpread),
    .vcoProfileBit(selVcoBit),
    .stateChoice(selStateChoice)
  );

  // state1 or state0 definition by the choice bit
  assign activeState = selStateChoice ? tpps_out_state_t'(routing_q[STATE_ONE_HI:STATE_ONE_LO])
                                      : tpps_out_state_t'(routing_q[STATE_ZERO_HI:STATE_ZERO_LO]);

  // bus next state: writes land in the data phase, reads registered in address phase
  always_comb
  begin
    wrPend_d = addrPhase && hwrite && addrInRange;
    wrIdx_d = addrIdx;
    rdData_d = rdData_q;
    spreadHi_d = spreadHi_q;
    spreadMid_d = spreadMid_q;
    spreadLo_d = spreadLo_q;
    vcoSel_d = vcoSel_q;
    routing_d = routing_q;
    stateSel_d = stateSel_q;
    direction_d = direction_q;
    if (wrPend_q)
    begin
      case (wrIdx_q)
        IDX_SPREAD_HI: spreadHi_d = hwdata[REG_W-1:0];
        IDX_SPREAD_MID: spreadMid_d = hwdata[REG_W-1:0];
        IDX_SPREAD_LO: spreadLo_d = hwdata[REG_W-1:0];
        IDX_VCO_SEL: vcoSel_d = hwdata[REG_W-1:0];
        IDX_ROUTING: routing_d = hwdata[REG_W-1:0];
        IDX_STATE_SEL: stateSel_d = hwdata[REG_W-1:0];
        // only the direction bit is kept; the rest belongs to other logic
        IDX_DIRECTION: direction_d = hwdata[REG_W-1:0] & (8'h01 << DIRECTION_BIT);
        default: ;
      endcase
    end
    if (addrPhase && !hwrite)
    begin
      rdData_d = 32'h00000000;
      if (addrInRange)
      begin
        case (addrIdx)
          IDX_SPREAD_HI: rdData_d = {24'h000000, spreadHi_q};
          IDX_SPREAD_MID: rdData_d = {24'h000000, spreadMid_q};
          IDX_SPREAD_LO: rdData_d = {24'h000000, spreadLo_q};
          IDX_VCO_SEL: rdData_d = {24'h000000, vcoSel_q};
          IDX_ROUTING: rdData_d = {24'h000000, routing_q};
          IDX_STATE_SEL: rdData_d = {24'h000000, stateSel_q};
          IDX_DIRECTION: rdData_d = {24'h000000, direction_q};
          // live view of what is applied right now
          IDX_STATUS: rdData_d = {24'h000000, spreadField_q, vcoBit_q, tristate_q, driveLow_q, enable_q, bypass_q};
          default: rdData_d = 32'h00000000;
        endcase
      end
    end
  end

  // bus and register flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPend_q <= 1'b0;
      wrIdx_q <= 8'h00;
      rdData_q <= 32'h00000000;
      spreadHi_q <= RST_SPREAD;
      spreadMid_q <= RST_SPREAD;
      spreadLo_q <= RST_SPREAD;
      vcoSel_q <= RST_VCO_SEL;
      routing_q <= RST_ROUTING;
      stateSel_q <= RST_STATE_SEL;
      direction_q <= RST_DIRECTION;
    end
    else
    begin
      wrPend_q <= wrPend_d;
      wrIdx_q <= wrIdx_d;
      rdData_q <= rdData_d;
      spreadHi_q <= spreadHi_d;
      spreadMid_q <= spreadMid_d;
      spreadLo_q <= spreadLo_d;
      vcoSel_q <= vcoSel_d;
      routing_q <= routing_d;
      stateSel_q <= stateSel_d;
      direction_q <= direction_d;
    end
  end

  // applied setting, one cycle behind registers and pins
  always_comb
  begin
    spreadField_d = selSpread;
    // amount decode, shared by both directions
    spreadAmt_d = tpps_spread_hundredths(selSpread);
    // center only matters when spread is on
    center_d = direction_q[DIRECTION_BIT] && (selSpread != 3'h0);
    vcoBit_d = selVcoBit;
    // profile word follows the profile bit
    profile_d = selVcoBit ? vcoProfileOne : vcoProfileZero;
    bypass_d = routing_q[BYPASS_BIT];
    // state code 00 also powers the pll down
    powerDown_d = routing_q[BYPASS_BIT] || (activeState == OST_OFF_PD);
    sixthSrc_d = routing_q[SIXTH_SRC_BIT];
    // seventh output source; reserved code passed as is
    seventhSrc_d = routing_q[SEVENTH_SRC_HI:SEVENTH_SRC_LO];
    tristate_d = 1'b0;
    driveLow_d = 1'b0;
    enable_d = 1'b0;
    case (activeState)
      OST_OFF_PD: tristate_d = 1'b1;
      OST_TRISTATE: tristate_d = 1'b1;
      OST_LOW: driveLow_d = 1'b1;
      OST_ON: enable_d = 1'b1;
      default: tristate_d = 1'b1;
    endcase
  end

  // output flops; reset mirrors the register defaults for setting 0, except the profile word, which resets to zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      spreadField_q <= 3'h0;
      spreadAmt_q <= 8'h00;
      center_q <= 1'b0;
      vcoBit_q <= 1'b0;
      profile_q <= 30'h00000000;
      bypass_q <= RST_ROUTING[BYPASS_BIT];
      powerDown_q <= 1'b1;
      sixthSrc_q <= RST_ROUTING[SIXTH_SRC_BIT];
      seventhSrc_q <= RST_ROUTING[SEVENTH_SRC_HI:SEVENTH_SRC_LO];
      tristate_q <= 1'b1;
      driveLow_q <= 1'b0;
      enable_q <= 1'b0;
    end
    else
    begin
      spreadField_q <= spreadField_d;
      spreadAmt_q <= spreadAmt_d;
      center_q <= center_d;
      vcoBit_q <= vcoBit_d;
      profile_q <= profile_d;
      bypass_q <= bypass_d;
      powerDown_q <= powerDown_d;
      sixthSrc_q <= sixthSrc_d;
      seventhSrc_q <= seventhSrc_d;
      tristate_q <= tristate_d;
      driveLow_q <= driveLow_d;
      enable_q <= enable_d;
    end
  end

  assign spreadAmountField = spreadField_q;
  assign spreadHundredths = spreadAmt_q;
  assign spreadCenter = center_q;
  assign vcoProfileBitOut = vcoBit_q;
  assign activeProfileWord = profile_q;
  assign pllBypass = bypass_q;
  assign pllPowerDown = powerDown_q;
  assign sixthOutSource = sixthSrc_q;
  assign seventhOutSource = seventhSrc_q;
  assign outTristate = tristate_q;
  assign outDriveLow = driveLow_q;
  assign outEnable = enable_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_routing_write;
    addrPhase && hwrite && addrInRange && (addrIdx == IDX_ROUTING);
  endsequence

  // a written routing byte lands, then steers bypass
  a_routing_write_lands: assert property (s_routing_write ##1 1'b1 |=> (routing_q == $past(hwdata[REG_W-1:0])) ##1 (pllBypass == $past(routing_q[BYPASS_BIT])))
    else $error("routing write did not reach bypass output");
  // quarter percent per step, top code jumps to two percent
  a_spread_amount_map: assert property (spreadHundredths == ((spreadAmountField == 3'h7) ? 8'hc8 : 8'(spreadAmountField * 8'h19)))
    else $error("spread amount does not match code");
  // center flag follows direction bit and nonzero code
  a_center_spread_flag: assert property (spreadCenter |-> $past(direction_q[DIRECTION_BIT]) && spreadAmountField != 3'h0)
    else $error("center flag without center direction");
  // a set profile bit brings the profile one word
  a_profile_word_match: assert property (vcoProfileBitOut |-> activeProfileWord == $past(vcoProfileOne))
    else $error("profile word not from profile one");
  // profile bit from the selected setting
  a_profile_bit_follow: assert property (##1 1'b1 |-> vcoProfileBitOut == $past(vcoSel_q[settingIdx]))
    else $error("profile bit not from selected setting");
  a_bypass_power_down: assert property (pllBypass |-> pllPowerDown)
    else $error("bypass without power down");
  // state code 00 tri-states and powers down
  a_state_power_down: assert property ((activeState == OST_OFF_PD) |=> pllPowerDown && outTristate)
    else $error("state code 00 did not power down");
  a_sixth_source_bit: assert property (##1 1'b1 |-> sixthOutSource == $past(routing_q[SIXTH_SRC_BIT]))
    else $error("sixth source mismatch");
  a_seventh_source_field: assert property (##1 1'b1 |-> seventhOutSource == $past(routing_q[SEVENTH_SRC_HI:SEVENTH_SRC_LO]))
    else $error("seventh source mismatch");
  // exactly one output state at a time, enable only for code 11
  a_output_state_onehot: assert property ($onehot({outTristate, outDriveLow, outEnable}) && (outEnable == ($past(activeState) == OST_ON)))
    else $error("output state mismatch");

endmodule : tpps_top

// [sim/tpps_host_model.sv]
`timescale 1ns/1ps
module tpps_host_model
  import tpps_pkg::*;
(
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic settingSelectPinA,
  output logic settingSelectPinB,
  output logic settingSelectPinC
);
  // idle bus and pins from time zero
  initial
  begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    {settingSelectPinC, settingSelectPinB, settingSelectPinA} = 3'h0;
  end

  // one single word transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic [IDX_W-1:0] idx, input logic wr, input logic [REG_W-1:0] wd,
                      output logic [31:0] rd);
    @(posedge clk);
    haddr <= {22'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    haddr <= ~{22'h0, idx, 2'b00}; // stale address must not be trusted
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~{24'h0, wd}; // released lane does not keep last value
  endtask : xfer

  task automatic write_reg(input logic [IDX_W-1:0] idx, input logic [REG_W-1:0] wd);
    logic [31:0] rd;
    if (idx <= 8'h40 && !(idx == IDX_ROUTING && wd[5:4] == 2'b11))
      xfer(idx, 1'b1, wd, rd);
  endtask : write_reg

  task automatic read_reg(input logic [IDX_W-1:0] idx, output logic [31:0] rd);
    xfer(idx, 1'b0, 8'h00, rd);
  endtask : read_reg

  task automatic set_pins(input logic [SEL_W-1:0] s);
    @(posedge clk);
    {settingSelectPinC, settingSelectPinB, settingSelectPinA} <= s;
  endtask : set_pins
endmodule : tpps_host_model

// [sim/third_pll_profile_select_bench.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module third_pll_profile_select_bench;
  import tpps_pkg::*;
  localparam logic [PROFILE_W-1:0] WORD_ZERO = 30'h15a5a5a5;
  localparam logic [PROFILE_W-1:0] WORD_ONE = 30'h2abcdef1;
  logic clk;
  logic nrst;
  logic hsel, hwrite, hreadyout, hresp, pinA, pinB, pinC;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, seventhOutSource;
  logic [2:0] hsize, spreadAmountField;
  logic [7:0] spreadHundredths;
  logic spreadCenter, vcoProfileBitOut, pllBypass, pllPowerDown, sixthOutSource;
  logic outTristate, outDriveLow, outEnable;
  logic [PROFILE_W-1:0] activeProfileWord;
  logic [7:0] amtTab [8] = '{8'h00, 8'h19, 8'h32, 8'h4b, 8'h64, 8'h7d, 8'h96, 8'hc8};
  logic [7:0] rstTab [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hed, 8'h02, 8'h00};
  int failures = 0;
  int compares = 0;

  tpps_top uut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .settingSelectPinA(pinA), .settingSelectPinB(pinB), .settingSelectPinC(pinC),
    .vcoProfileZero(WORD_ZERO), .vcoProfileOne(WORD_ONE), .spreadAmountField(spreadAmountField),
    .spreadHundredths(spreadHundredths), .spreadCenter(spreadCenter), .vcoProfileBitOut(vcoProfileBitOut),
    .activeProfileWord(activeProfileWord), .pllBypass(pllBypass), .pllPowerDown(pllPowerDown),
    .sixthOutSource(sixthOutSource), .seventhOutSource(seventhOutSource), .outTristate(outTristate),
    .outDriveLow(outDriveLow), .outEnable(outEnable));

  tpps_host_model host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .settingSelectPinA(pinA),
    .settingSelectPinB(pinB), .settingSelectPinC(pinC));

  // free running clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // expected {powerdown, tristate, low, enable} for a state code without bypass
  function automatic logic [3:0] st_exp(input logic [1:0] c);
    return {c == 2'b00, c <= 2'b01, c == 2'b10, c == 2'b11};
  endfunction : st_exp

  // select a setting and look once its decode has landed
  task automatic pick(input int n);
    host.set_pins(3'(n));
    @(posedge clk);
    @(negedge clk);
  endtask : pick

  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] d;
    host.read_reg(idx, d);
    `CHK(nm, {24'h0, e}, d)
  endtask : rdchk

  task automatic t_reset;
    for (int i = 0; i < 7; i++)
      rdchk("reset value", 8'(8'h30 + i), rstTab[i]);
    pick(0);
    `CHK("routing", 4'b1110, {pllBypass, sixthOutSource, seventhOutSource})
    `CHK("state0 default", 4'b1100, {pllPowerDown, outTristate, outDriveLow, outEnable})
    pick(1);
    `CHK("state1 default", 4'b1001, {pllPowerDown, outTristate, outDriveLow, outEnable})
    $display("test reset done");
  endtask : t_reset

  task automatic t_spread;
    // setting n carries code n, so straddling fields show up at once
    host.write_reg(IDX_SPREAD_HI, 8'hfa);
    host.write_reg(IDX_SPREAD_MID, 8'hc6);
    host.write_reg(IDX_SPREAD_LO, 8'h88);
    for (int d = 0; d < 2; d++)
    begin
      host.write_reg(IDX_DIRECTION, d ? 8'hff : 8'h00);
      rdchk("direction reg", IDX_DIRECTION, d ? 8'h80 : 8'h00);
      for (int n = 0; n < 8; n++)
      begin
        pick(n);
        `CHK("spread code", 3'(n), spreadAmountField)
        `CHK("spread amount", amtTab[n], spreadHundredths)
        `CHK("center", 1'((d != 0) && (n != 0)), spreadCenter)
      end
    end
    $display("test spread done");
  endtask : t_spread

  task automatic t_vco;
    host.write_reg(IDX_VCO_SEL, 8'ha5);
    for (int n = 0; n < 8; n++)
    begin
      pick(n);
      `CHK("profile bit", 1'(8'ha5 >> n), vcoProfileBitOut)
      `CHK("profile word", (8'ha5 >> n) & 1 ? WORD_ONE : WORD_ZERO, activeProfileWord)
    end
    $display("test vco done");
  endtask : t_vco

  task automatic t_route;
    logic [1:0] c;
    logic [1:0] sev;
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i);
      sev = (c == 2'b11) ? 2'b10 : c;
      host.write_reg(IDX_ROUTING, {1'b0, c[0], sev, c, ~c});
      for (int p = 0; p < 2; p++)
      begin
        pick(p);
        `CHK("routing", {1'b0, c[0], sev}, {pllBypass, sixthOutSource, seventhOutSource})
        `CHK("out state", st_exp(p ? c : ~c), {pllPowerDown, outTristate, outDriveLow, outEnable})
      end
    end
    // last pass left state1 enabled and state0 powered down
    host.write_reg(IDX_STATE_SEL, 8'hfd);
    pick(1);
    `CHK("state choice", st_exp(2'b00), {pllPowerDown, outTristate, outDriveLow, outEnable})
    pick(7);
    `CHK("state choice", st_exp(2'b11), {pllPowerDown, outTristate, outDriveLow, outEnable})
    // status: code 7, profile bit 1, enabled, no bypass
    rdchk("status", IDX_STATUS, 8'hf2);
    $display("test route done");
  endtask : t_route

  task automatic t_unmapped;
    host.write_reg(8'h37, 8'h55);
    rdchk("unmapped", 8'h37, 8'h00);
    rdchk("above top", 8'h50, 8'h00);
    `CHK("response", HRESP_OKAY, hresp)
    `CHK("ready", 1'b1, hreadyout)
    $display("test unmapped done");
  endtask : t_unmapped

  task automatic conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  // reset then the scenarios in turn
  initial
  begin
    nrst = 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_spread();
    t_vco();
    t_route();
    t_unmapped();
    conclude();
  end

  // the scenarios need under two hundred cycles; 40000 leaves ample margin
  initial
  begin
    #2000000;
    failures++;
    conclude();
  end
endmodule : third_pll_profile_select_bench
